// File: dpm_map_consts.svh
`ifndef DPM_MAP_CONSTS_SVH
`define DPM_MAP_CONSTS_SVH

// Register indexes; byte address is four times the index
`define DPM_IDX_REMAP_EN 12'h33e
`define DPM_IDX_06_07 12'h343
`define DPM_IDX_08_09 12'h344
`define DPM_IDX_0A_0B 12'h345
`define DPM_IDX_0C_0D 12'h346
`define DPM_IDX_0E_0F 12'h347
`define DPM_IDX_10_11 12'h348
`define DPM_IDX_12_13 12'h349
`define DPM_IDX_14_15 12'h34a
`define DPM_IDX_16_17 12'h34b
`define DPM_IDX_18_19 12'h34c
`define DPM_IDX_1A_1B 12'h34d
`define DPM_IDX_1C_1D 12'h34e

// Table layout
`define DPM_MAP_COUNT 12
`define DPM_MAP_BASE_PAIR 5'h03
`define DPM_LO_LSB 0
`define DPM_HI_LSB 4
`define DPM_MAP_RESET 6'h00
`define DPM_REMAP_EN_BIT 0
`define DPM_REMAP_SPARE_BIT 1

// Internal slot codes
`define DPM_SLOT_REMAP 4'hc
`define DPM_SLOT_NONE 4'hf

`endif

// File: dpm_pkg.sv
package dpm_pkg;

    // One mapping register: upper field odd code, lower field even code
    typedef struct packed {
        logic [2:0] hi;
        logic [2:0] lo;
    } dpm_pair_t;

    typedef struct packed {
        logic valid;
        logic [5:0] dscp;
    } dpm_query_t;

    typedef struct packed {
        logic valid;
        logic miss;
        logic [2:0] prio;
    } dpm_result_t;

endpackage

// File: dpm_field_sel.sv
`include "dpm_map_consts.svh"
module dpm_field_sel
    import dpm_pkg::*;
(
    // Table contents
    input wire dpm_pair_t [11:0] map_tbl,
    // Code to look up
    input wire logic [5:0] dscp,
    // Selection
    output logic [2:0] prio,
    output logic miss
);

    logic [11:0] hit;
    logic [2:0] pick [12];

    genvar i;
    generate
        for (i = 0; i < `DPM_MAP_COUNT; i++)
        begin : g_entry
            // Register chosen by code shifted right, offset by table base
            assign hit[i] = (dscp[5:1] == (5'(i) + `DPM_MAP_BASE_PAIR));
            assign pick[i] = !hit[i] ? 3'h0 :
                             (dscp[0] ? map_tbl[i].hi : map_tbl[i].lo);
        end
    endgenerate

    always_comb
    begin
        prio = 3'h0;
        for (int k = 0; k < `DPM_MAP_COUNT; k++)
        begin
            prio = prio | pick[k];
        end
    end

    // Codes outside this slice are flagged as a miss, with prio zero
    assign miss = ~|hit;

endmodule // dpm_field_sel

// File: dpm_map_bank.sv
`include "dpm_map_consts.svh"
module dpm_map_bank
    import dpm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Lookup
    input wire dpm_query_t query,
    output dpm_result_t result
);

    dpm_pair_t [11:0] map_tbl;
    logic remap_en;
    logic remap_spare;
    logic apb_setup;
    logic wr_fire;
    logic aligned;
    logic [3:0] req_slot;
    logic [31:0] next_rdata;
    logic [2:0] tbl_prio;
    logic tbl_miss;

    // Register index to internal slot
    function automatic logic [3:0] slot_of(input logic [11:0] idx);
        logic [3:0] s;
        s = `DPM_SLOT_NONE;
        if (idx == `DPM_IDX_REMAP_EN)
            s = `DPM_SLOT_REMAP;
        else if (idx == `DPM_IDX_06_07)
            s = 4'h0;
        else if (idx == `DPM_IDX_08_09)
            s = 4'h1;
        else if (idx == `DPM_IDX_0A_0B)
            s = 4'h2;
        else if (idx == `DPM_IDX_0C_0D)
            s = 4'h3;
        else if (idx == `DPM_IDX_0E_0F)
            s = 4'h4;
        else if (idx == `DPM_IDX_10_11)
            s = 4'h5;
        else if (idx == `DPM_IDX_12_13)
            s = 4'h6;
        else if (idx == `DPM_IDX_14_15)
            s = 4'h7;
        else if (idx == `DPM_IDX_16_17)
            s = 4'h8;
        else if (idx == `DPM_IDX_18_19)
            s = 4'h9;
        else if (idx == `DPM_IDX_1A_1B)
            s = 4'ha;
        else if (idx == `DPM_IDX_1C_1D)
            s = 4'hb;
        return s;
    endfunction

    // Unaligned or out-of-window addresses are unmapped
    assign aligned = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0);
    assign req_slot = aligned ? slot_of(paddr[13:2]) : `DPM_SLOT_NONE;
    assign apb_setup = psel && !penable;
    // Writes land only at the completing edge, and only through byte lane 0
    assign wr_fire = psel && penable && pready && pwrite && pstrb[0];

    // Mapping registers
    genvar i;
    generate
        for (i = 0; i < `DPM_MAP_COUNT; i++)
        begin : g_map
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    map_tbl[i] <= `DPM_MAP_RESET;
                end
                else if (wr_fire && req_slot == 4'(i))
                begin
                    // Bits 7 and 3 have no storage, so writes there vanish
                    map_tbl[i].hi <= pwdata[`DPM_HI_LSB +: 3];
                    map_tbl[i].lo <= pwdata[`DPM_LO_LSB +: 3];
                end
            end
        end
    endgenerate

    // Remap enable register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            remap_en <= 1'b0;
            remap_spare <= 1'b0;
        end
        else if (wr_fire && req_slot == `DPM_SLOT_REMAP)
        begin
            remap_en <= pwdata[`DPM_REMAP_EN_BIT];
            remap_spare <= pwdata[`DPM_REMAP_SPARE_BIT];
        end
    end

    // Read data
    always_comb
    begin
        next_rdata = 32'h0;
        if (req_slot == `DPM_SLOT_REMAP)
        begin
            next_rdata[`DPM_REMAP_EN_BIT] = remap_en;
            next_rdata[`DPM_REMAP_SPARE_BIT] = remap_spare;
        end
        else if (req_slot < `DPM_SLOT_REMAP)
        begin
            next_rdata[`DPM_HI_LSB +: 3] = map_tbl[req_slot].hi;
            next_rdata[`DPM_LO_LSB +: 3] = map_tbl[req_slot].lo;
        end
    end

    // Answer one cycle after setup: zero wait states, outputs registered
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= apb_setup;
            if (apb_setup)
            begin
                prdata <= pwrite ? 32'h0 : next_rdata;
                pslverr <= (req_slot == `DPM_SLOT_NONE);
            end
        end
    end

    dpm_field_sel u_sel
    (
        .map_tbl(map_tbl),
        .dscp(query.dscp),
        .prio(tbl_prio),
        .miss(tbl_miss)
    );

    // Lookup result, one cycle after the query; prio and miss hold between queries, valid drops
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            result <= '0;
        end
        else
        begin
            result.valid <= query.valid;
            if (query.valid)
            begin
                if (remap_en)
                begin
                    result.prio <= tbl_prio;
                    result.miss <= tbl_miss;
                end
                else
                begin
                    result.prio <= query.dscp[5:3];
                    result.miss <= 1'b0;
                end
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    // Helper: no APB write, to any address or lane, has completed since reset
    logic wr_seen;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            wr_seen <= 1'b0;
        else if (psel && penable && pready && pwrite)
            wr_seen <= 1'b1;
    end

    property map_write_p(logic [11:0] idx, int slot);
        psel && penable && pready && pwrite && pstrb[0] && paddr == {2'h0, idx, 2'h0}
        |=> map_tbl[slot] == {$past(pwdata[6:4]), $past(pwdata[2:0])};
    endproperty

    map_wr_0607_a: assert property (map_write_p(`DPM_IDX_06_07, 0))
        else $error("Write to 0x343 not stored");
    map_wr_0809_a: assert property (map_write_p(`DPM_IDX_08_09, 1))
        else $error("Write to 0x344 not stored");
    map_wr_0a0b_a: assert property (map_write_p(`DPM_IDX_0A_0B, 2))
        else $error("Write to 0x345 not stored");
    map_wr_0c0d_a: assert property (map_write_p(`DPM_IDX_0C_0D, 3))
        else $error("Write to 0x346 not stored");
    map_wr_0e0f_a: assert property (map_write_p(`DPM_IDX_0E_0F, 4))
        else $error("Write to 0x347 not stored");
    map_wr_1011_a: assert property (map_write_p(`DPM_IDX_10_11, 5))
        else $error("Write to 0x348 not stored");
    map_wr_1213_a: assert property (map_write_p(`DPM_IDX_12_13, 6))
        else $error("Write to 0x349 not stored");
    map_wr_1415_a: assert property (map_write_p(`DPM_IDX_14_15, 7))
        else $error("Write to 0x34a not stored");
    map_wr_1617_a: assert property (map_write_p(`DPM_IDX_16_17, 8))
        else $error("Write to 0x34b not stored");
    map_wr_1819_a: assert property (map_write_p(`DPM_IDX_18_19, 9))
        else $error("Write to 0x34c not stored");
    map_wr_1a1b_a: assert property (map_write_p(`DPM_IDX_1A_1B, 10))
        else $error("Write to 0x34d not stored");
    map_wr_1c1d_a: assert property (map_write_p(`DPM_IDX_1C_1D, 11))
        else $error("Write to 0x34e not stored");

    reset_zero_a: assert property (!wr_seen |-> map_tbl == '0)
        else $error("Table not zero before any write");

    readback_a: assert property (
        apb_setup && !pwrite && paddr == {2'h0, `DPM_IDX_1C_1D, 2'h0}
        |=> pready && !pslverr
            && prdata == {25'h0, $past(map_tbl[11].hi), 1'b0, $past(map_tbl[11].lo)})
        else $error("Readback of 0x34e wrong");

    reserved_zero_a: assert property (
        pready && psel && penable && !pwrite
        |-> prdata[31:8] == 24'h0 && !prdata[7] && !prdata[3])
        else $error("Reserved read bits not zero");

    miss_flag_a: assert property (
        query.valid && remap_en && query.dscp > 6'h1d
        |=> result.valid && result.miss && result.prio == 3'h0)
        else $error("Uncovered code not flagged");

    table_lo_a: assert property (
        query.valid && remap_en && query.dscp == 6'h06
        |=> result.prio == $past(map_tbl[0].lo) && !result.miss)
        else $error("Code 06 not taken from table");

    bypass_a: assert property (
        query.valid && !remap_en
        |=> result.valid && !result.miss && result.prio == $past(query.dscp[5:3]))
        else $error("Bypass priority wrong");

    odd_upper_a: assert property (
        query.valid && remap_en && query.dscp == 6'h13
        |=> result.prio == $past(map_tbl[6].hi))
        else $error("Code 13 not from upper field");

    answer_time_a: assert property (
        apb_setup |=> pready ##1 !pready || (psel && !penable))
        else $error("Slave answer timing wrong");

    pready_phase_a: assert property (pready |-> psel && penable)
        else $error("Ready outside access phase");

    write_resp_a: assert property (
        apb_setup && pwrite |=> pready && prdata == 32'h0)
        else $error("Write answer carries data");

    // Holes in the map answer with an error, never with stale data
    unmapped_err_a: assert property (
        apb_setup && paddr == {2'h0, 12'h34f, 2'h0}
        |=> pready && pslverr && prdata == 32'h0)
        else $error("Unmapped index not refused");

    unaligned_err_a: assert property (
        apb_setup && paddr[1:0] != 2'h0 |=> pready && pslverr)
        else $error("Unaligned address not refused");

    strobe_off_a: assert property (
        psel && penable && pready && pwrite && !pstrb[0]
        |=> $stable(map_tbl) && $stable(remap_en))
        else $error("Write without lane 0 changed state");

    remap_wr_a: assert property (
        psel && penable && pready && pwrite && pstrb[0] && paddr == {2'h0, `DPM_IDX_REMAP_EN, 2'h0}
        |=> remap_en == $past(pwdata[`DPM_REMAP_EN_BIT]))
        else $error("Remap enable write not stored");

    remap_rd_a: assert property (
        apb_setup && !pwrite && paddr == {2'h0, `DPM_IDX_REMAP_EN, 2'h0}
        |=> prdata == {30'h0, $past(remap_spare), $past(remap_en)})
        else $error("Remap enable readback wrong");

    low_miss_a: assert property (
        query.valid && remap_en && query.dscp < 6'h06
        |=> result.valid && result.miss && result.prio == 3'h0)
        else $error("Low code not flagged");

    table_hi_a: assert property (
        query.valid && remap_en && query.dscp == 6'h1d
        |=> result.prio == $past(map_tbl[11].hi) && !result.miss)
        else $error("Code 1d not taken from table");

    result_pulse_a: assert property (query.valid |=> result.valid)
        else $error("Query not answered");

    // Priority and miss must hold so a late consumer still reads them
    result_hold_a: assert property (
        !query.valid |=> !result.valid && $stable(result.prio) && $stable(result.miss))
        else $error("Result changed without a query");

    // Every covered code, even and odd, lands on its own register field
    genvar j;
    generate
        for (j = 0; j < `DPM_MAP_COUNT; j++)
        begin : g_look_chk
            entry_pick_a: assert property (
                query.valid && remap_en && query.dscp[5:1] == 5'(j) + `DPM_MAP_BASE_PAIR
                |=> result.valid && !result.miss
                    && result.prio == ($past(query.dscp[0]) ? $past(map_tbl[j].hi)
                                                           : $past(map_tbl[j].lo)))
                else $error("Table entry lookup wrong");
        end
    endgenerate

    wr_rd_c: cover property (
        wr_fire && req_slot == 4'h5 ##[1:20] apb_setup && !pwrite && req_slot == 4'h5);
    remap_hit_c: cover property (
        remap_en && query.valid && !tbl_miss ##1 result.prio != 3'h0);
    remap_miss_c: cover property (remap_en && query.valid && tbl_miss);
    slverr_c: cover property (pready && pslverr);

endmodule // dpm_map_bank

// File: tb.sv
module tb
    import dpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct {
        logic [11:0] idx;
        logic [7:0] wr;
        logic [7:0] rd;
    } dpm_row_t;

    logic clk;
    logic nrst;
    logic psel;
    logic penable;
    logic pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0] pstrb;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    dpm_query_t query;
    dpm_result_t result;
    dpm_row_t rows [12];
    int n_mismatch;
    int n_checks;
    int cycles;

    dpm_map_bank u_dpm_map_bank (
        .clk(clk),
        .nrst(nrst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .query(query),
        .result(result)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Ceiling well above the roughly 400 cycles the sequence needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            n_mismatch++;
            conclude();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic logic [15:0] ba(input logic [11:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction

    // Holds the whole request until pready is sampled high
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d,
                       input logic [3:0] s, output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic look(input logic [5:0] c, input logic [2:0] p, input logic m);
        @(posedge clk);
        query.valid <= 1'b1;
        query.dscp <= c;
        @(posedge clk);
        query.valid <= 1'b0;
        #1;
        chk("result valid", {31'h0, result.valid}, 32'h1);
        chk("result prio", {29'h0, result.prio}, {29'h0, p});
        chk("result miss", {31'h0, result.miss}, {31'h0, m});
    endtask

    initial
    begin
        int i;
        int c;
        logic [31:0] rd;
        logic err;
        logic [2:0] p;
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
        pstrb = 4'h0;
        query = '0;
        // Reserved bits 7 and 3 set in every write pattern
        for (i = 0; i < 12; i++)
        begin
            rows[i].idx = 12'h343 + 12'(i);
            rows[i].wr = 8'h88 | {1'b0, 3'(i + 3), 1'b0, 3'(7 - i)};
            rows[i].rd = rows[i].wr & 8'h77;
        end
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        for (i = 0; i < 12; i++)
        begin
            apb(1'b0, ba(rows[i].idx), 8'h00, 4'h1, rd, err);
            chk("reset value", rd, 32'h0);
        end
        for (c = 0; c < 64; c++)
            look(6'(c), 3'(c >> 3), 1'b0);
        for (i = 0; i < 12; i++)
        begin
            apb(1'b1, ba(rows[i].idx), rows[i].wr, 4'h1, rd, err);
            apb(1'b0, ba(rows[i].idx), 8'h00, 4'h1, rd, err);
            chk("map readback", rd, {24'h0, rows[i].rd});
            chk("map error", {31'h0, err}, 32'h0);
        end
        apb(1'b1, ba(12'h33e), 8'hff, 4'h1, rd, err);
        apb(1'b0, ba(12'h33e), 8'h00, 4'h1, rd, err);
        chk("remap enable", rd, 32'h3);
        for (c = 0; c < 64; c++)
        begin
            if (c >= 6 && c <= 29)
            begin
                i = (c >> 1) - 3;
                p = c[0] ? rows[i].rd[6:4] : rows[i].rd[2:0];
                look(6'(c), p, 1'b0);
            end
            else
                look(6'(c), 3'h0, 1'b1);
        end
        // Strobe off: write dropped without error
        apb(1'b1, ba(12'h343), 8'h00, 4'h0, rd, err);
        chk("strobe off error", {31'h0, err}, 32'h0);
        apb(1'b0, ba(12'h343), 8'h00, 4'h1, rd, err);
        chk("strobe off", rd, {24'h0, rows[0].rd});
        apb(1'b0, ba(12'h34f), 8'h00, 4'h1, rd, err);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", rd, 32'h0);
        apb(1'b0, ba(12'h343) | 16'h0001, 8'h00, 4'h1, rd, err);
        chk("unaligned error", {31'h0, err}, 32'h1);
        // Table change seen by the very next query
        apb(1'b1, ba(12'h349), 8'h70, 4'h1, rd, err);
        look(6'h13, 3'h7, 1'b0);
        look(6'h12, 3'h0, 1'b0);
        apb(1'b1, ba(12'h33e), 8'h00, 4'h1, rd, err);
        look(6'h13, 3'h2, 1'b0);
        // Reset in mid-run clears table and enable
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, ba(12'h349), 8'h00, 4'h1, rd, err);
        chk("map after reset", rd, 32'h0);
        apb(1'b0, ba(12'h33e), 8'h00, 4'h1, rd, err);
        chk("remap after reset", rd, 32'h0);
        conclude();
    end
endmodule // tb
